// >>> core/sgp_pkg.sv
package sgp_pkg;

   // Register byte offsets
   localparam logic [11:0] SGP_OFF_MODE = 12'h000;
   localparam logic [11:0] SGP_OFF_CTRL = 12'h004;
   localparam logic [11:0] SGP_OFF_CMD = 12'h008;
   localparam logic [11:0] SGP_OFF_STAT = 12'h00C;

   // Reset values
   localparam logic [7:0] SGP_MODE_RST = 8'h00;
   localparam logic [1:0] SGP_CTRL_RST = 2'h0;

   // Control bit positions
   localparam int SGP_CTRL_SWI = 0;
   localparam int SGP_CTRL_WAKE = 1;

   // Command bit positions
   localparam int SGP_CMD_SET = 0;
   localparam int SGP_CMD_CLR = 1;
   localparam int SGP_CMD_TOIN = 2;
   localparam int SGP_CMD_AUTH = 3;
   localparam int SGP_CMD_AUTHCLR = 4;
   localparam int SGP_CMD_QUERY = 5;

   // Glitch filter length in cycles
   localparam int SGP_FILT_CYC = 5;

   typedef enum logic [5:0] {
      SGP_DISABLED = 6'h01,
      SGP_AUTH_OUT = 6'h02,
      SGP_INTRUSION = 6'h04,
      SGP_PLAIN_IN = 6'h08,
      SGP_FREE_OUT = 6'h10,
      SGP_UNINIT = 6'h20
   } sgp_mode_t;

   typedef struct packed {
      logic set_req;
      logic clr_req;
      logic to_input_req;
      logic auth_ok;
      logic auth_clr;
      logic query;
   } sgp_cmd_t;

   typedef struct packed {
      logic drive_en;
      logic level;
   } sgp_pin_t;

   function automatic sgp_mode_t sgp_decode(input logic [3:0] m);
      case (m[1:0])
         2'b00: sgp_decode = SGP_DISABLED;
         2'b01: sgp_decode = m[3] ? SGP_INTRUSION : SGP_AUTH_OUT;
         2'b10: sgp_decode = SGP_PLAIN_IN;
         default: sgp_decode = SGP_FREE_OUT;
      endcase
   endfunction

endpackage

// >>> core/sgp_sync_filt.sv
`timescale 1ns/10ps
module sgp_sync_filt import sgp_pkg::*; #(
   parameter int FILT = SGP_FILT_CYC
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Pin in
   input wire logic pin_in,
   // Filtered level and edge
   output logic level_q,
   output logic fall_q
);
   logic s1_q, s2_q;
   logic [7:0] cnt_q;

   ////////////////////////////////////////////////////////////
   // Two-stage synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
      end
   end

   ////////////////////////////////////////////////////////////
   // Glitch filter, single fall pulse per edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 8'h00;
         level_q <= 1'b1;
         fall_q <= 1'b0;
      end else begin
         fall_q <= 1'b0;
         if (s2_q == level_q) begin
            cnt_q <= 8'h00;
         end else if (cnt_q >= 8'(FILT - 1)) begin
            cnt_q <= 8'h00;
            level_q <= s2_q;
            fall_q <= level_q & ~s2_q; // [RULE21]
         end else begin
            cnt_q <= cnt_q + 8'h01;
         end
      end
   end
endmodule

// >>> core/sgp_apb_regs.sv
`timescale 1ns/10ps
module sgp_apb_regs import sgp_pkg::*; (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Register state
   output logic [7:0] mode_byte_q,
   output logic [1:0] ctrl_q,
   output sgp_cmd_t cmd_q,
   input wire logic [31:0] stat
);
   logic acc;
   assign acc = psel & penable;

   ////////////////////////////////////////////////////////////
   // Writable registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_byte_q <= SGP_MODE_RST;
         ctrl_q <= SGP_CTRL_RST;
      end else if (acc && pwrite) begin
         if (paddr == SGP_OFF_MODE) mode_byte_q <= pwdata[7:0];
         if (paddr == SGP_OFF_CTRL) ctrl_q <= pwdata[1:0];
      end
   end

   ////////////////////////////////////////////////////////////
   // Command strobes, one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_q <= '0;
      end else if (acc && pwrite && paddr == SGP_OFF_CMD) begin
         cmd_q.set_req <= pwdata[SGP_CMD_SET];
         cmd_q.clr_req <= pwdata[SGP_CMD_CLR];
         cmd_q.to_input_req <= pwdata[SGP_CMD_TOIN];
         cmd_q.auth_ok <= pwdata[SGP_CMD_AUTH];
         cmd_q.auth_clr <= pwdata[SGP_CMD_AUTHCLR];
         cmd_q.query <= pwdata[SGP_CMD_QUERY];
      end else begin
         cmd_q <= '0;
      end
   end

   ////////////////////////////////////////////////////////////
   // Read and response
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         if (psel && !penable) begin
            case (paddr)
               SGP_OFF_MODE: prdata <= {24'h00_0000, mode_byte_q};
               SGP_OFF_CTRL: prdata <= {30'h0000_0000, ctrl_q};
               SGP_OFF_CMD: prdata <= 32'h0000_0000;
               SGP_OFF_STAT: prdata <= stat;
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end
endmodule

// >>> core/sgp_gpio.sv
`timescale 1ns/10ps
// Function
// [RULE1] Pin acts as GPIO only while single-wire interface is selected.
// [RULE2] After power-up the pin stays an input until initialization.
// [RULE3] First wake reads the mode byte, then sets direction and level.
// [RULE4] Direction and output level hold through sleep and idle.
// [RULE5] Mode bits 1:0 zero: pin unused input, requests return error.
// [RULE6] Requests return error while configured for I2C.
// [RULE7] Mode 0001: permanent output, driven low at first wake.
// [RULE8] Authorized modes: non-default level only after prior authorization.
// [RULE9] Authorized modes: return to default level needs no authorization.
// [RULE10] Mode 0101: as 0001 but drives high after power-up.
// [RULE11] Intrusion mode: permanent input, latch cleared at power-up.
// [RULE12] Intrusion latch is set only by successful authorization.
// [RULE13] Any pin falling edge clears the intrusion latch, awake or asleep; the code lets an authorization in the same cycle win and set it.
// [RULE14] Intrusion-mode query returns the latch, not the pin level.
// [RULE15] Mode x010: permanent input, query reports present pin level.
// [RULE16] Mode x011: low at first wake, then high or low freely.
// [RULE17] Free-output modes: a request turns the pin into an input.
// [RULE18] Mode x111: as x011 but drives high after power-up.
// [RULE19] As an output the pin actively drives high and low.
// [RULE20] Controller should use input, not high, to extinguish a high-rail LED.
// [RULE21] Falling edges come from a synchronised, glitch-filtered pin copy.
module sgp_gpio import sgp_pkg::*; #(
   parameter int FILT = SGP_FILT_CYC
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pin
   input wire logic pin_i,
   output logic pin_o,
   output logic pin_oe
);
   logic [7:0] mode_byte;
   logic [1:0] ctrl;
   sgp_cmd_t cmd;
   logic [31:0] stat;
   logic pin_lvl, pin_fall;
   sgp_mode_t mode_q;
   logic [3:0] cfg_q;
   logic dflt_q;
   logic authed_q;
   logic latch_q;
   logic drive_q;
   logic level_q;
   logic err_q;
   logic ans_q;
   logic wake_d1_q;
   logic swi;
   logic first_wake;

   ////////////////////////////////////////////////////////////
   // Register slave
   sgp_apb_regs u_regs (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .mode_byte_q(mode_byte),
      .ctrl_q(ctrl),
      .cmd_q(cmd),
      .stat(stat)
   );

   ////////////////////////////////////////////////////////////
   // Pin input conditioning
   sgp_sync_filt #(.FILT(FILT)) u_filt (
      .pclk(pclk),
      .presetn(presetn),
      .pin_in(pin_i),
      .level_q(pin_lvl),
      .fall_q(pin_fall)
   );

   assign swi = ctrl[SGP_CTRL_SWI];
   assign first_wake = ctrl[SGP_CTRL_WAKE] & ~wake_d1_q & (mode_q == SGP_UNINIT);

   ////////////////////////////////////////////////////////////
   // Wake edge tracking
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_d1_q <= 1'b0;
      end else begin
         wake_d1_q <= ctrl[SGP_CTRL_WAKE];
      end
   end

   ////////////////////////////////////////////////////////////
   // Mode capture at first wake
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= SGP_UNINIT; // [RULE2]
         cfg_q <= 4'h0;
      end else if (first_wake) begin
         mode_q <= sgp_decode(mode_byte[3:0]); // [RULE3]
         cfg_q <= mode_byte[3:0];
      end
   end

   assign dflt_q = cfg_q[2];

   ////////////////////////////////////////////////////////////
   // Authorization record
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         authed_q <= 1'b0;
      end else if (cmd.auth_ok) begin
         authed_q <= 1'b1;
      end else if (cmd.auth_clr) begin
         authed_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////
   // Intrusion latch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_q <= 1'b0; // [RULE11]
      end else if (mode_q != SGP_INTRUSION) begin
         latch_q <= 1'b0;
      end else if (cmd.auth_ok) begin
         latch_q <= 1'b1; // [RULE12]
      end else if (pin_fall) begin
         latch_q <= 1'b0; // [RULE13]
      end
   end

   ////////////////////////////////////////////////////////////
   // Pin drive, held through sleep and idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive_q <= 1'b0;
         level_q <= 1'b0;
      end else if (!swi) begin
         drive_q <= 1'b0; // [RULE1]
         if (first_wake) begin
            level_q <= mode_byte[2];
         end
      end else if (first_wake) begin
         case (sgp_decode(mode_byte[3:0]))
            SGP_AUTH_OUT: begin
               drive_q <= 1'b1; // [RULE7]
               level_q <= mode_byte[2]; // [RULE10]
            end
            SGP_FREE_OUT: begin
               drive_q <= 1'b1; // [RULE16]
               level_q <= mode_byte[2]; // [RULE18]
            end
            default: begin
               drive_q <= 1'b0; // [RULE5] [RULE11] [RULE15]
            end
         endcase
      end else begin
         case (mode_q)
            SGP_AUTH_OUT: begin
               drive_q <= 1'b1;
               if (cmd.clr_req || cmd.set_req) begin
                  if ((cmd.set_req ? 1'b1 : 1'b0) == dflt_q) begin
                     level_q <= dflt_q; // [RULE9]
                  end else if (authed_q) begin
                     level_q <= ~dflt_q; // [RULE8]
                  end
               end
            end
            SGP_FREE_OUT: begin
               if (cmd.to_input_req) begin
                  drive_q <= 1'b0; // [RULE17]
               end else if (cmd.set_req) begin
                  drive_q <= 1'b1;
                  level_q <= 1'b1;
               end else if (cmd.clr_req) begin
                  drive_q <= 1'b1;
                  level_q <= 1'b0;
               end
            end
            default: begin
               drive_q <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////
   // Request answers and errors
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_q <= 1'b0;
         ans_q <= 1'b0;
      end else if (cmd.set_req || cmd.clr_req || cmd.to_input_req || cmd.query) begin
         err_q <= 1'b0;
         if (!swi) begin
            err_q <= 1'b1; // [RULE6]
         end else begin
            case (mode_q)
               SGP_DISABLED, SGP_UNINIT: err_q <= 1'b1; // [RULE5]
               SGP_INTRUSION: ans_q <= latch_q; // [RULE14]
               SGP_PLAIN_IN: ans_q <= pin_lvl; // [RULE15]
               SGP_AUTH_OUT: begin
                  ans_q <= level_q;
                  if ((cmd.set_req || cmd.clr_req) && cmd.set_req != dflt_q && !authed_q) begin
                     err_q <= 1'b1; // [RULE8]
                  end
               end
               default: ans_q <= drive_q ? level_q : pin_lvl;
            endcase
         end
      end
   end

   assign stat = {24'h00_0000, mode_q == SGP_UNINIT, authed_q, latch_q, pin_lvl, drive_q, level_q, ans_q, err_q};

   ////////////////////////////////////////////////////////////
   // Pin outputs, both levels actively driven
   assign pin_o = level_q; // [RULE19]
   assign pin_oe = drive_q; // [RULE4]
endmodule

// >>> verif/sgp_gpio_checker.sv
`timescale 1ns/10ps
module sgp_gpio_checker import sgp_pkg::*; #(
   parameter int FILT = SGP_FILT_CYC
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pin
   input wire logic pin_i,
   input wire logic pin_o,
   input wire logic pin_oe
);
   logic wr, outm, inm, woke_q, swi_q, auth_q;
   logic [3:0] mode_q;
   assign wr = psel && penable && pready && pwrite;
   assign outm = woke_q && swi_q && (mode_q[1:0] == 2'h3 || mode_q[1:0] == 2'h1 && !mode_q[3]);
   assign inm = mode_q[1:0] == 2'h0 || mode_q[1:0] == 2'h2 || mode_q[3] && mode_q[1:0] == 2'h1;
   ////////////////////
   // Shadow of written state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {woke_q, swi_q, auth_q, mode_q} <= 7'h00;
      end else if (wr) begin
         if (paddr == SGP_OFF_MODE && !woke_q) mode_q <= pwdata[3:0];
         if (paddr == SGP_OFF_CTRL) {woke_q, swi_q} <= {woke_q | pwdata[1], pwdata[0]};
         if (paddr == SGP_OFF_CMD && (pwdata[3] || pwdata[4])) auth_q <= pwdata[3];
      end
   end
   ////////////////////
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   property p_ready; psel && !penable |=> pready; endproperty
   a_ready: assert property (p_ready) else $error("no answer after setup");
   property p_slverr; pready |-> pslverr == (paddr > 12'h00C || paddr[1:0] != 2'h0); endproperty
   a_slverr: assert property (p_slverr) else $error("wrong pslverr");
   property p_swi; !swi_q [*2] |-> !pin_oe; endproperty
   a_swi: assert property (p_swi) else $error("pin driven in two-wire use");
   property p_uninit; !woke_q |-> !pin_oe; endproperty
   a_uninit: assert property (p_uninit) else $error("pin driven before wake");
   property p_default; $rose(woke_q) && outm |-> ##[1:2] (pin_oe && pin_o == mode_q[2]); endproperty
   a_default: assert property (p_default) else $error("wrong level at wake");
   property p_inmode; woke_q && inm |-> !pin_oe; endproperty
   a_inmode: assert property (p_inmode) else $error("input mode drives pin");
   property p_stable; !psel [*4] |-> $stable(pin_oe) && $stable(pin_o); endproperty
   a_stable: assert property (p_stable) else $error("pin moved while idle");
   property p_auth;
      woke_q && mode_q[1:0] == 2'h1 && !mode_q[3] && pin_oe && pin_o != mode_q[2] && $past(pin_o) == mode_q[2]
         |-> auth_q || $past(auth_q, 3);
   endproperty
   a_auth: assert property (p_auth) else $error("unauthorized level");
   c_wake: cover property ($rose(woke_q) && outm);
   c_err: cover property (pready && pslverr);
   c_nondef: cover property (auth_q && pin_oe && pin_o != mode_q[2]);
endmodule
bind sgp_gpio sgp_gpio_checker #(.FILT(FILT)) u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .pin_i, .pin_o, .pin_oe);

// >>> verif/sgp_ext.sv
`timescale 1ns/10ps
module sgp_ext (
   // Device side
   input wire logic pin_o,
   input wire logic pin_oe,
   // Switch and pin
   input wire logic sw_closed,
   output logic pin_i
);
   // Pull-up unless the switch grounds it
   assign pin_i = pin_oe ? pin_o : !sw_closed;
endmodule

// >>> verif/secure_gpio_pin_control_tb.sv
`timescale 1ns/10ps
module secure_gpio_pin_control_tb;
   import sgp_pkg::*;
   localparam int F = 2;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sw = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, eq[$], mq[$];
   logic pready, pslverr, pin_i, pin_o, pin_oe, d;
   logic [3:0] m;
   logic [7:0] mb;
   logic [3:0] tbl[7] = '{4'h0, 4'h1, 4'h5, 4'h9, 4'h2, 4'h3, 4'h7};
   int bad_count = 0, total_checks = 0, cyc = 0;
   always #5 pclk = ~pclk;
   sgp_gpio #(.FILT(F)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .pin_i, .pin_o, .pin_oe);
   sgp_ext ext (.pin_o, .pin_oe, .sw_closed(sw), .pin_i);
   ////////////////////
   task automatic chk(input string s, input logic [31:0] v, input logic [31:0] e);
      total_checks++;
      if (v !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", s, e, v);
      end
   endtask
   task automatic print_verdict;
      if (bad_count == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dt);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, dt};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      {psel, penable} <= 2'h0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] mk);
      eq.push_back(e & mk);
      mq.push_back(mk);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic cmd(input int b);
      apb(1'b1, SGP_OFF_CMD, 32'h1 << b);
      repeat (3) @(posedge pclk);
   endtask
   task automatic pin(input logic oe, input logic o);
      chk("pin_oe", pin_oe, oe);
      if (oe) chk("pin_o", pin_o, o);
   endtask
   task automatic boot(input logic [3:0] md, input logic s);
      presetn <= 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rd(SGP_OFF_MODE, SGP_MODE_RST, 32'hFF);
      rd(SGP_OFF_CTRL, SGP_CTRL_RST, 32'h3);
      rd(SGP_OFF_STAT, 32'h80, 32'h88);
      rd(12'h010, 32'h0, 32'hFFFFFFFF);
      mb = {4'($urandom), md};
      apb(1'b1, SGP_OFF_MODE, {24'h0, mb});
      rd(SGP_OFF_MODE, {24'h0, mb}, 32'hFF);
      apb(1'b1, SGP_OFF_CTRL, {30'h0, 1'b1, s});
      repeat (3) @(posedge pclk);
   endtask
   ////////////////////
   // Read result monitor and timeout
   always @(posedge pclk) begin
      cyc++;
      if (psel && penable && pready && !pwrite) begin
         chk("prdata", prdata & mq[0], eq[0]);
         void'(eq.pop_front());
         void'(mq.pop_front());
      end
      if (cyc == 20000) begin
         bad_count++;
         print_verdict;
      end
   end
   ////////////////////
   initial begin
      void'($urandom(32'h6C04D6B7));
      foreach (tbl[i]) begin
         m = tbl[i];
         d = m[2];
         boot(m, 1'b1);
         pin(m[1:0] == 2'h3 || m[1:0] == 2'h1 && !m[3], d);
         if (m[1:0] == 2'h0) begin
            cmd(SGP_CMD_SET);
            rd(SGP_OFF_STAT, 32'h1, 32'h9);
         end else if (m[1:0] == 2'h1 && !m[3]) begin
            cmd(d ? SGP_CMD_CLR : SGP_CMD_SET);
            pin(1'b1, d);
            cmd(SGP_CMD_AUTH);
            cmd(d ? SGP_CMD_CLR : SGP_CMD_SET);
            pin(1'b1, !d);
            cmd(SGP_CMD_AUTHCLR);
            cmd(d ? SGP_CMD_SET : SGP_CMD_CLR);
            pin(1'b1, d);
         end else if (m[1:0] == 2'h1) begin
            cmd(SGP_CMD_AUTH);
            cmd(SGP_CMD_QUERY);
            rd(SGP_OFF_STAT, 32'h22, 32'h2A);
            sw <= 1'b1;
            repeat (F + 6) @(posedge pclk);
            sw <= 1'b0;
            cmd(SGP_CMD_QUERY);
            rd(SGP_OFF_STAT, 32'h0, 32'h22);
         end else if (m[1:0] == 2'h2) begin
            sw <= 1'($urandom);
            repeat (F + 6) @(posedge pclk);
            cmd(SGP_CMD_QUERY);
            rd(SGP_OFF_STAT, {30'h0, !sw, 1'b0}, 32'hA);
            sw <= 1'b0;
         end else begin
            cmd(SGP_CMD_SET);
            apb(1'b1, SGP_OFF_CTRL, 32'h1);
            repeat (3) @(posedge pclk);
            pin(1'b1, 1'b1);
            cmd(SGP_CMD_CLR);
            pin(1'b1, 1'b0);
            cmd(SGP_CMD_TOIN);
            pin(1'b0, 1'b0);
         end
      end
      boot(4'h3, 1'b0);
      pin(1'b0, 1'b0);
      cmd(SGP_CMD_SET);
      rd(SGP_OFF_STAT, 32'h1, 32'h9);
      print_verdict;
   end
endmodule
